// [core/tpc_role_ctrl.sv]
// Type-C port role selection, attach detection and notify outputs
`timescale 1ns/1ps
module tpc_role_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Configuration
    input wire logic addr_strap_pin,
    input wire logic enable_n,
    input wire logic role_wr,
    input wire logic [1:0] role_wdata,
    input wire logic soft_reset_wr,
    input wire logic pending_clr,
    // Line sense
    input wire logic cc1_rd_seen,
    input wire logic cc2_rd_seen,
    input wire logic cc1_rp_seen,
    input wire logic cc2_rp_seen,
    input wire logic bus_power_sense_pin,
    // Status
    output logic i2c_mode,
    output logic [6:0] i2c_addr,
    output logic [1:0] role_sel,
    output logic soft_reset,
    output logic [1:0] attached_state,
    output logic cable_dir,
    output logic change_pending,
    output logic present_source,
    // Pins
    output logic change_notify_pin_o,
    output logic change_notify_pin_oe,
    output logic host_role_indicator_pin_o,
    output logic host_role_indicator_pin_oe,
    output logic orient_pin
);
    tpc_pkg::tpc_state_type st_r, st_nxt;
    logic [1:0] role_r, role_nxt;
    logic srst_r, srst_nxt;
    logic en_n_r, en_n_nxt;
    logic dir_r, dir_nxt;
    logic pend_r, pend_nxt;
    logic [1:0] att_r, att_nxt;
    logic drp_ld, deb_ld, drp_exp, deb_exp;
    logic leave_mode, drp, cc_rd, cc_rp, det_dir;

    // Strap either way means I2C; no floating level is resolvable here
    assign i2c_mode = 1'b1;
    assign i2c_addr = addr_strap_pin ? tpc_pkg::ADDR_STRAP_HIGH : tpc_pkg::ADDR_STRAP_LOW;

    assign drp = (role_r == tpc_pkg::ROLE_DRP) || (role_r == tpc_pkg::ROLE_DRP_ALT);
    assign leave_mode = (role_wr && role_wdata != role_r) || srst_r || (!enable_n && en_n_r);
    assign cc_rd = cc1_rd_seen || cc2_rd_seen;
    assign cc_rp = cc1_rp_seen || cc2_rp_seen;
    // Flag follows physical input; a swapped board inverts meaning
    assign det_dir = (st_r == tpc_pkg::ST_ATT_WAIT_SRC) ? cc2_rd_seen : cc2_rp_seen;

    tpc_timer #(.W(tpc_pkg::CNT_W)) u_drp_tmr (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .load(drp_ld),
        .load_val(tpc_pkg::CNT_W'(tpc_pkg::DRP_HALF_CYC)),
        .expired(drp_exp)
    );
    tpc_timer #(.W(tpc_pkg::CNT_W)) u_deb_tmr (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .load(deb_ld),
        .load_val(tpc_pkg::CNT_W'(tpc_pkg::DEBOUNCE_CYC)),
        .expired(deb_exp)
    );

    always_comb begin
        st_nxt = st_r;
        role_nxt = role_wr ? role_wdata : role_r;
        srst_nxt = soft_reset_wr;
        en_n_nxt = enable_n;
        dir_nxt = dir_r;
        att_nxt = att_r;
        drp_ld = 1'b0;
        deb_ld = 1'b0;
        case (st_r)
            tpc_pkg::ST_UNATT_SNK: begin
                deb_ld = 1'b1;
                if (bus_power_sense_pin && cc_rp) begin
                    st_nxt = tpc_pkg::ST_ATT_WAIT_SNK;
                end else if (drp && drp_exp) begin
                    st_nxt = tpc_pkg::ST_UNATT_SRC;
                    drp_ld = 1'b1;
                end
            end
            tpc_pkg::ST_UNATT_SRC: begin
                deb_ld = 1'b1;
                if (cc_rd) begin
                    st_nxt = tpc_pkg::ST_ATT_WAIT_SRC;
                end else if (drp && drp_exp) begin
                    st_nxt = tpc_pkg::ST_UNATT_SNK;
                    drp_ld = 1'b1;
                end
            end
            tpc_pkg::ST_ATT_WAIT_SNK: begin
                if (!(bus_power_sense_pin && cc_rp)) begin
                    st_nxt = tpc_pkg::ST_UNATT_SNK;
                end else if (deb_exp) begin
                    st_nxt = tpc_pkg::ST_ATT_SNK;
                    att_nxt = tpc_pkg::ATT_SNK;
                    dir_nxt = det_dir;
                end
            end
            tpc_pkg::ST_ATT_WAIT_SRC: begin
                if (!cc_rd) begin
                    st_nxt = tpc_pkg::ST_UNATT_SRC;
                end else if (deb_exp) begin
                    st_nxt = tpc_pkg::ST_ATT_SRC;
                    att_nxt = tpc_pkg::ATT_SRC;
                    dir_nxt = det_dir;
                end
            end
            tpc_pkg::ST_ATT_SNK: begin
                if (!bus_power_sense_pin) begin
                    st_nxt = tpc_pkg::ST_UNATT_SNK;
                    att_nxt = tpc_pkg::ATT_NONE;
                end
            end
            tpc_pkg::ST_ATT_SRC: begin
                if (!cc_rd) begin
                    st_nxt = tpc_pkg::ST_UNATT_SRC;
                    att_nxt = tpc_pkg::ATT_NONE;
                end
            end
            default: begin
                st_nxt = tpc_pkg::ST_UNATT_SNK;
            end
        endcase
        if (leave_mode) begin
            att_nxt = tpc_pkg::ATT_NONE;
            drp_ld = 1'b1;
            st_nxt = (role_nxt == tpc_pkg::ROLE_DFP) ? tpc_pkg::ST_UNATT_SRC : tpc_pkg::ST_UNATT_SNK;
            if (srst_r) begin
                dir_nxt = tpc_pkg::ORIENT_RESET;
            end
        end
        // Set wins over a simultaneous clear so no change is lost
        pend_nxt = pend_r;
        if (pending_clr) begin
            pend_nxt = 1'b0;
        end
        if (att_nxt != att_r || dir_nxt != dir_r || role_nxt != role_r) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_r <= tpc_pkg::ST_UNATT_SNK;
            role_r <= tpc_pkg::ROLE_RESET;
            srst_r <= 1'b0;
            // Idle level is enabled, so no false falling edge follows reset
            en_n_r <= 1'b0;
            dir_r <= tpc_pkg::ORIENT_RESET;
            pend_r <= 1'b0;
            att_r <= tpc_pkg::ATT_NONE;
        end else begin
            st_r <= st_nxt;
            role_r <= role_nxt;
            srst_r <= srst_nxt;
            en_n_r <= en_n_nxt;
            dir_r <= dir_nxt;
            pend_r <= pend_nxt;
            att_r <= att_nxt;
        end
    end

    assign role_sel = role_r;
    assign soft_reset = srst_r;
    assign attached_state = att_r;
    assign cable_dir = dir_r;
    assign change_pending = pend_r;
    // Sink pulldowns are the powered-off default; analog keeps them unpowered
    assign present_source = (st_r == tpc_pkg::ST_UNATT_SRC) || (st_r == tpc_pkg::ST_ATT_WAIT_SRC)
        || (st_r == tpc_pkg::ST_ATT_SRC);
    assign change_notify_pin_o = 1'b0;
    assign change_notify_pin_oe = pend_r;
    assign host_role_indicator_pin_o = 1'b0;
    assign host_role_indicator_pin_oe = drp && (att_r == tpc_pkg::ATT_SRC);
    assign orient_pin = dir_r;

    a_notify_on_change: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !$stable(att_r) || !$stable(dir_r) || !$stable(role_r) |-> change_notify_pin_oe && !change_notify_pin_o)
        else $error("notify pin not pulled on change");
    a_pend_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pend_r && !pending_clr |=> pend_r) else $error("pending dropped without clear");
    a_srst_selfclr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        srst_r && !soft_reset_wr |=> !srst_r) else $error("soft reset did not clear");
    a_srst_unattach: assert property (@(posedge ref_clk) disable iff (!reset_n)
        srst_r |=> att_r == tpc_pkg::ATT_NONE) else $error("soft reset kept attach");
    a_role_dfp_src: assert property (@(posedge ref_clk) disable iff (!reset_n)
        srst_r && role_r == tpc_pkg::ROLE_DFP && !role_wr |=> st_r == tpc_pkg::ST_UNATT_SRC)
        else $error("source role not restarted as source");
    a_attach_debounced: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(att_r == tpc_pkg::ATT_SRC) |-> $past(st_r) == tpc_pkg::ST_ATT_WAIT_SRC)
        else $error("source attach without debounce");
    a_id_low_src: assert property (@(posedge ref_clk) disable iff (!reset_n)
        host_role_indicator_pin_oe |-> st_r == tpc_pkg::ST_ATT_SRC && drp)
        else $error("indicator low outside attached source");
    a_orient_pin: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !$stable(orient_pin) |-> attached_state != tpc_pkg::ATT_NONE || $past(srst_r))
        else $error("orientation pin moved outside attach");
    a_addr_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !addr_strap_pin |-> i2c_addr == 7'h47) else $error("wrong strap-low address");
    a_fixed_ufp_stays: assert property (@(posedge ref_clk) disable iff (!reset_n)
        role_r == tpc_pkg::ROLE_UFP && !leave_mode |=> !present_source)
        else $error("sink role presented source");
endmodule

// [common/tpc_pkg.sv]
// Constants and types for the Type-C port role controller
package tpc_pkg;
    // Role-select encodings
    localparam logic [1:0] ROLE_DRP = 2'h0;
    localparam logic [1:0] ROLE_UFP = 2'h1;
    localparam logic [1:0] ROLE_DFP = 2'h2;
    localparam logic [1:0] ROLE_DRP_ALT = 2'h3;
    localparam logic [1:0] ROLE_RESET = 2'h0;
    // I2C target addresses by strap level
    localparam logic [6:0] ADDR_STRAP_LOW = 7'h47;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h67;
    // Attached-state encodings
    localparam logic [1:0] ATT_NONE = 2'h0;
    localparam logic [1:0] ATT_SRC = 2'h1;
    localparam logic [1:0] ATT_SNK = 2'h2;
    // Orientation reset value: second line
    localparam logic ORIENT_RESET = 1'b1;
    // Timing: DRP toggle half period and attach debounce
    localparam int CLK_PERIOD_NS = 4;
    localparam int DRP_HALF_US = 35;
    localparam int DRP_HALF_CYC = (DRP_HALF_US * 1000) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    typedef enum logic [2:0] {
        ST_UNATT_SNK,
        ST_UNATT_SRC,
        ST_ATT_WAIT_SNK,
        ST_ATT_WAIT_SRC,
        ST_ATT_SNK,
        ST_ATT_SRC
    } tpc_state_type;
endpackage

// [core/tpc_timer.sv]
// Reloadable down counter flagging expiry
`timescale 1ns/1ps
module tpc_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Status
    output logic expired
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_val;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            // Start loaded so the first period after reset runs its full length
            cnt_r <= load_val;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // From the count only: the caller's load depends on this flag
    assign expired = (cnt_r == '0);
endmodule

// [verif/tpc_partner.sv]
// Port partner on the CC lines and VBUS, plus the local bus controller
`timescale 1ns/1ps
module tpc_partner (
    // Scenario: kind 0 none, 1 sink partner, 2 source partner
    input wire logic [1:0] kind,
    input wire logic flip,
    // Device side
    input wire logic present_source,
    input wire logic host_role_indicator_pin_oe,
    // Line sense, plus the controller's bus power enable
    output logic cc1_rd_seen,
    output logic cc2_rd_seen,
    output logic cc1_rp_seen,
    output logic cc2_rp_seen,
    output logic bus_power_sense_pin,
    output logic host_vbus_en
);
    // Pulldown seen only while the device presents a pullup
    assign cc1_rd_seen = (kind == 2'h1) && present_source && !flip;
    assign cc2_rd_seen = (kind == 2'h1) && present_source && flip;
    assign cc1_rp_seen = (kind == 2'h2) && !present_source && !flip;
    assign cc2_rp_seen = (kind == 2'h2) && !present_source && flip;
    // Only a source partner powers the bus; the sense pulldown holds it low otherwise
    assign bus_power_sense_pin = (kind == 2'h2);
    // Controller hosts and powers the bus only once the indicator is low
    assign host_vbus_en = host_role_indicator_pin_oe;
endmodule

// [verif/tpc_role_ctrl_tb.sv]
// Self-checking bench for the port role controller
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, m); end end
module tpc_role_ctrl_tb;
    typedef struct packed {
        logic [1:0] role;
        logic [1:0] kind;
        logic flip;
        logic [1:0] att;
        logic ind;
    } tpc_row_type;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic addr_strap_pin = 1'b0;
    logic enable_n = 1'b0;
    logic role_wr = 1'b0;
    logic [1:0] role_wdata = 2'h0;
    logic soft_reset_wr = 1'b0;
    logic pending_clr = 1'b0;
    logic [1:0] kind = 2'h0;
    logic flip = 1'b0;
    logic cc1_rd_seen, cc2_rd_seen, cc1_rp_seen, cc2_rp_seen, bus_power_sense_pin, host_vbus_en;
    logic i2c_mode, soft_reset, cable_dir, change_pending, present_source, orient_pin;
    logic [6:0] i2c_addr;
    logic [1:0] role_sel, attached_state;
    logic change_notify_pin_o, change_notify_pin_oe, host_role_indicator_pin_o, host_role_indicator_pin_oe;
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    tpc_row_type rows [4] = '{
        '{tpc_pkg::ROLE_DRP, 2'h1, 1'b0, tpc_pkg::ATT_SRC, 1'b1},
        '{tpc_pkg::ROLE_DRP_ALT, 2'h2, 1'b1, tpc_pkg::ATT_SNK, 1'b0},
        '{tpc_pkg::ROLE_DFP, 2'h1, 1'b1, tpc_pkg::ATT_SRC, 1'b0},
        '{tpc_pkg::ROLE_UFP, 2'h2, 1'b0, tpc_pkg::ATT_SNK, 1'b0}
    };

    tpc_role_ctrl DUT (.ref_clk, .reset_n, .addr_strap_pin, .enable_n, .role_wr, .role_wdata, .soft_reset_wr,
        .pending_clr, .cc1_rd_seen, .cc2_rd_seen, .cc1_rp_seen, .cc2_rp_seen, .bus_power_sense_pin, .i2c_mode,
        .i2c_addr, .role_sel, .soft_reset, .attached_state, .cable_dir, .change_pending, .present_source,
        .change_notify_pin_o, .change_notify_pin_oe, .host_role_indicator_pin_o, .host_role_indicator_pin_oe,
        .orient_pin);
    tpc_partner partner (.kind, .flip, .present_source, .host_role_indicator_pin_oe, .cc1_rd_seen, .cc2_rd_seen,
        .cc1_rp_seen, .cc2_rp_seen, .bus_power_sense_pin, .host_vbus_en);

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
    endtask

    task automatic stop_test();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        tick(1);
        reset_n <= 1'b0;
        kind <= 2'h0;
        tick(4);
        reset_n <= 1'b1;
        tick(1);
    endtask

    task automatic write_role(input logic [1:0] v);
        tick(1);
        role_wr <= 1'b1;
        role_wdata <= v;
        tick(1);
        role_wr <= 1'b0;
    endtask

    // Bounded: worst case is one dual-role half period plus debounce
    task automatic wait_attach(output int c);
        c = 0;
        #1;
        while (attached_state === tpc_pkg::ATT_NONE && c < 20000) begin
            tick(1);
            #1;
            c++;
        end
        if (c >= 20000) begin
            error_cnt++;
            $display("CHECK FAILED %0t attach wait expired", $time);
        end
    endtask

    initial begin
        do_reset();
        #1;
        `CHK(role_sel, tpc_pkg::ROLE_RESET, "role after reset")
        `CHK(attached_state, tpc_pkg::ATT_NONE, "attach after reset")
        `CHK(cable_dir, tpc_pkg::ORIENT_RESET, "dir after reset")
        `CHK(present_source, 1'b0, "sink at reset")
        `CHK({change_pending, change_notify_pin_oe, host_role_indicator_pin_oe}, 3'h0, "idle outputs")
        `CHK({change_notify_pin_o, host_role_indicator_pin_o}, 2'h0, "open-drain level")
        `CHK({i2c_mode, i2c_addr}, {1'b1, tpc_pkg::ADDR_STRAP_LOW}, "low strap")
        tick(1);
        addr_strap_pin <= 1'b1;
        #1;
        `CHK({i2c_mode, i2c_addr}, {1'b1, tpc_pkg::ADDR_STRAP_HIGH}, "high strap")
        tick(tpc_pkg::DRP_HALF_CYC + 20);
        #1;
        `CHK(present_source, 1'b1, "toggled to source")
        tick(tpc_pkg::DRP_HALF_CYC);
        #1;
        `CHK(present_source, 1'b0, "toggled back to sink")
        foreach (rows[i]) begin
            do_reset();
            if (rows[i].role != tpc_pkg::ROLE_DRP) begin
                write_role(rows[i].role);
            end
            tick(1);
            kind <= rows[i].kind;
            flip <= rows[i].flip;
            wait_attach(n);
            `CHK(n > tpc_pkg::DEBOUNCE_CYC - 4, 1'b1, "attach before debounce")
            `CHK(role_sel, rows[i].role, "role field")
            `CHK(attached_state, rows[i].att, "attach kind")
            `CHK(cable_dir, rows[i].flip, "orientation bit")
            `CHK(orient_pin, rows[i].flip, "mux steering")
            `CHK(host_role_indicator_pin_oe, rows[i].ind, "host indicator")
            `CHK(host_vbus_en, rows[i].ind, "controller bus power")
            `CHK(change_notify_pin_oe, 1'b1, "notify on attach")
        end
        tick(100);
        #1;
        `CHK(change_pending, 1'b1, "pending held")
        tick(1);
        pending_clr <= 1'b1;
        tick(1);
        pending_clr <= 1'b0;
        tick(1);
        #1;
        `CHK({change_pending, change_notify_pin_oe}, 2'h0, "notify released")
        write_role(tpc_pkg::ROLE_DFP);
        tick(3);
        #1;
        `CHK(attached_state, tpc_pkg::ATT_NONE, "role change leaves mode")
        `CHK(present_source, 1'b1, "restart as source")
        `CHK(change_pending, 1'b1, "pending on change")
        tick(1);
        kind <= 2'h1;
        wait_attach(n);
        tick(1);
        soft_reset_wr <= 1'b1;
        tick(1);
        soft_reset_wr <= 1'b0;
        #1;
        `CHK(soft_reset, 1'b1, "soft reset set")
        tick(1);
        #1;
        `CHK(soft_reset, 1'b0, "soft reset self clear")
        tick(2);
        #1;
        `CHK(attached_state, tpc_pkg::ATT_NONE, "soft reset leaves mode")
        wait_attach(n);
        tick(1);
        enable_n <= 1'b1;
        tick(2);
        #1;
        `CHK(attached_state, tpc_pkg::ATT_SRC, "enable rise keeps attach")
        tick(1);
        enable_n <= 1'b0;
        tick(3);
        #1;
        `CHK(attached_state, tpc_pkg::ATT_NONE, "enable fall leaves mode")
        stop_test();
    end

    // Whole sequence needs about 42000 cycles
    initial begin
        #320000;
        error_cnt++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        stop_test();
    end
endmodule
